/* logic/fbs_pkg.sv */
`default_nettype none
package fbs_pkg;

	// ************************************************************
	// Completion codes on the status output
	// ************************************************************
	localparam logic [1:0] FBS_ST_OK     = 2'h0; // Finished cleanly
	localparam logic [1:0] FBS_ST_FIX    = 2'h1; // One bit corrected, or protection / unmodified buffer
	localparam logic [1:0] FBS_ST_UNCORR = 2'h2; // Two or more bit errors; a word with two or more left as read
	localparam logic [1:0] FBS_ST_WEAR   = 2'h3; // Other page pending, or wear threshold passed

	// ************************************************************
	// Page status word layout
	// ************************************************************
	localparam int FBS_CNT_W       = 24;
	localparam int FBS_CNT_LSB     = 8;
	localparam int FBS_OVER_BIT    = 3;
	localparam int FBS_RPROT_BIT   = 2;
	localparam int FBS_WPROT_BIT   = 1;
	localparam int FBS_OWLOCK_BIT  = 0;
	localparam logic [FBS_CNT_W-1:0] FBS_CNT_RST = 24'h000000;

	typedef struct packed {
		logic [FBS_CNT_W-1:0] count;
		logic [3:0]           rsvd;
		logic                 over;
		logic                 rd_prot;
		logic                 wr_prot;
		logic                 ow_lock;
	} fbs_page_info_t;

	// ************************************************************
	// Software register port
	// ************************************************************
	localparam logic [3:0] FBS_REG_IRQ_STAT = 4'h0;
	localparam logic [3:0] FBS_REG_IRQ_MASK = 4'h4;
	localparam logic [3:0] FBS_REG_LAST     = 4'h8;
	localparam logic [3:0] FBS_REG_PROT     = 4'hc;
	localparam int         FBS_PROT_PG_LSB  = 8;
	localparam int         FBS_IRQ_DONE     = 0;
	localparam int         FBS_IRQ_ERR      = 1;
	localparam logic [1:0] FBS_IRQ_MASK_RST = 2'h0;
	localparam logic [1:0] FBS_IRQ_STAT_RST = 2'h0;

	// Wear threshold default, in program/erase cycles
	localparam logic [FBS_CNT_W-1:0] FBS_WEAR_LIMIT_DEF = 24'h0003e8;

	typedef enum logic [1:0] {FBS_IDLE, FBS_UNLOCK, FBS_PROGRAM, FBS_ERASE} fbs_state_t;

endpackage : fbs_pkg
`default_nettype wire

/* logic/fbs_flash_block.sv */
// Operation
// - Two-bit status reports last completed operation; 00 means success.
// - Read or unlock with exactly one bit error corrects data, reports 01.
// - Read or unlock with two or more bit errors reports 10; a word with two or more is left uncorrected.
// - Locked-page write, protected erase, unmodified or protected program report 01.
// - Write to another page while buffered page unprogrammed reports 11.
// - Erase or program on page past wear threshold reports 11.
// - Unlock request copies page into buffer, then buffer becomes writable.
// - Write strobe stores the 32-bit write word into the page buffer.
// - All inputs active high except the active-low reset.
// - Status word bits 31..8 hold page program/erase count.
// - Status word bit 3 flags over threshold; bits 7..4 read zero.
// - Bits 2 and 1 show read/write protect flags, set externally.
// - Bit 0 shows overwrite lock from program; writes refused until unlock.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fbs_flash_block
	import fbs_pkg::*;
#(
	parameter int                   PAGES      = 8,
	parameter int                   WORDS      = 32,
	parameter logic [FBS_CNT_W-1:0] WEAR_LIMIT = FBS_WEAR_LIMIT_DEF,
	localparam int                  PW         = $clog2(PAGES),
	localparam int                  WW         = $clog2(WORDS)
) (
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	input  wire logic          clk_en,
	input  wire logic [PW-1:0] page_addr,
	input  wire logic [WW-1:0] word_addr,
	input  wire logic [31:0]   write_word,
	input  wire logic          write_strobe,
	input  wire logic          read_strobe,
	input  wire logic          page_info_select,
	input  wire logic          page_unlock_request,
	input  wire logic          program_request,
	input  wire logic          erase_request,
	input  wire logic          overwrite_lock_request,
	input  wire logic [31:0]   fault_mask,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_write,
	input  wire logic          reg_read,
	output logic [31:0]        reg_rdata,
	output logic [31:0]        read_word,
	output logic [1:0]         status,
	output logic               op_done,
	output logic               busy,
	output logic               irq
);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	if (PAGES < 2 || (1 << PW) != PAGES || PW > 8) begin : g_bad_pages
		$error("PAGES must be a power of two from 2 to 256");
	end
	if (WORDS < 2 || (1 << WW) != WORDS) begin : g_bad_words
		$error("WORDS must be a power of two of at least 2");
	end

	// ************************************************************
	// Storage
	// ************************************************************
	// Three copies per word; majority vote stands in for the array code
	logic [31:0]          copy0 [PAGES*WORDS];
	logic [31:0]          copy1 [PAGES*WORDS];
	logic [31:0]          copy2 [PAGES*WORDS];
	logic [31:0]          buf_mem [WORDS];
	logic [FBS_CNT_W-1:0] wcount_r [PAGES];
	logic [PAGES-1:0]     lock_r;
	logic [PAGES-1:0]     rprot_r;
	logic [PAGES-1:0]     wprot_r;
	logic [PAGES-1:0]     over;

	// ************************************************************
	// Sequencer and buffer state
	// ************************************************************
	fbs_state_t     state_r;
	fbs_state_t     state_nxt;
	logic [PW-1:0]  op_page_r;
	logic [WW-1:0]  idx_r;
	logic [1:0]     err_acc_r;
	logic           ow_req_r;
	logic [PW-1:0]  buf_page_r;
	logic           buf_dirty_r;
	logic [WORDS-1:0] buf_mask_r;
	logic [31:0]    fault_q1_r;
	logic [31:0]    fault_q2_r;
	logic [1:0]     irq_stat_r;
	logic [1:0]     irq_mask_r;
	logic [31:0]    reg_rdata_r;
	logic [31:0]    read_word_r;
	logic [1:0]     status_r;
	logic           op_done_r;
	logic           busy_r;
	logic           irq_r;

	// Saturating count of differing bit positions: 0, 1 or 2 (two or more)
	function automatic logic [1:0] err_level(input logic [31:0] dis);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, dis[i]};
		end
		return (n > 6'h01) ? 2'h2 : n[1:0];
	endfunction : err_level

	// Saturating sum of two error levels
	function automatic logic [1:0] err_sum(input logic [1:0] a, input logic [1:0] b);
		logic [2:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s > 3'h2) ? 2'h2 : s[1:0];
	endfunction : err_sum

	// ************************************************************
	// Array read path with error check
	// ************************************************************
	wire                         idle     = (state_r == FBS_IDLE);
	wire                         last_idx = (idx_r == WW'(WORDS - 1));
	wire [PW+WW-1:0]             rd_addr  = idle ? {page_addr, word_addr} : {op_page_r, idx_r};
	wire [31:0]                  c0       = copy0[rd_addr] ^ fault_q2_r;
	wire [31:0]                  c1       = copy1[rd_addr];
	wire [31:0]                  c2       = copy2[rd_addr];
	wire [31:0]                  vote     = (c0 & c1) | (c0 & c2) | (c1 & c2);
	wire [1:0]                   word_err = err_level((c0 ^ c1) | (c0 ^ c2));
	wire [31:0]                  word_out = (word_err == 2'h2) ? c0 : vote;

	// Page status word for the addressed page
	fbs_page_info_t info;
	assign info.count   = wcount_r[page_addr];
	assign info.rsvd    = 4'h0;
	assign info.over    = over[page_addr];
	assign info.rd_prot = rprot_r[page_addr];
	assign info.wr_prot = wprot_r[page_addr];
	assign info.ow_lock = lock_r[page_addr];

	// ************************************************************
	// Request decode; one request taken per idle cycle, in this priority
	// ************************************************************
	wire go_unlock = idle & page_unlock_request;
	wire go_prog   = idle & ~page_unlock_request & program_request;
	wire go_erase  = idle & ~page_unlock_request & ~program_request & erase_request;
	wire any_big   = page_unlock_request | program_request | erase_request;
	wire go_write  = idle & ~any_big & write_strobe;
	wire go_read   = idle & ~any_big & ~write_strobe & read_strobe;
	wire same_buf  = (buf_page_r == page_addr);

	// Program: unmodified buffer or lock first, then wear
	wire [1:0] prog_chk  = (lock_r[page_addr] | ~buf_dirty_r | ~same_buf) ? FBS_ST_FIX
		: over[page_addr] ? FBS_ST_WEAR : FBS_ST_OK;
	wire [1:0] erase_chk = lock_r[page_addr] ? FBS_ST_FIX
		: over[page_addr] ? FBS_ST_WEAR : FBS_ST_OK;
	// Pending page beats lock, since the buffered data would be lost either way
	wire [1:0] write_chk = (buf_dirty_r & ~same_buf) ? FBS_ST_WEAR
		: lock_r[page_addr] ? FBS_ST_FIX : FBS_ST_OK;

	// ************************************************************
	// Completion of an operation
	// ************************************************************
	wire       seq_end  = ~idle & last_idx;
	wire [1:0] unl_err  = err_sum(err_acc_r, word_err);
	wire       fin      = go_write | go_read | seq_end
		| (go_prog & (prog_chk != FBS_ST_OK)) | (go_erase & (erase_chk != FBS_ST_OK));
	wire [1:0] fin_stat = go_write ? write_chk
		: go_read ? (page_info_select ? FBS_ST_OK : word_err)
		: go_prog ? prog_chk
		: go_erase ? erase_chk
		: (state_r == FBS_UNLOCK) ? unl_err : FBS_ST_OK;
	wire [31:0] read_nxt = page_info_select ? 32'(info) : word_out;

	// Next state of the sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FBS_IDLE: begin
				if (go_unlock) begin
					state_nxt = FBS_UNLOCK;
				end else if (go_prog && prog_chk == FBS_ST_OK) begin
					state_nxt = FBS_PROGRAM;
				end else if (go_erase && erase_chk == FBS_ST_OK) begin
					state_nxt = FBS_ERASE;
				end
			end
			default: begin
				if (last_idx) begin
					state_nxt = FBS_IDLE;
				end
			end
		endcase
	end

	// ************************************************************
	// Array and buffer write ports, one word per cycle
	// ************************************************************
	wire              arr_we    = (state_r == FBS_PROGRAM) | (state_r == FBS_ERASE);
	wire [PW+WW-1:0]  arr_waddr = {op_page_r, idx_r};
	// Unmasked buffer words keep the array's voted contents
	wire [31:0]       arr_wdata = (state_r == FBS_ERASE) ? 32'h00000000
		: buf_mask_r[idx_r] ? buf_mem[idx_r] : vote;
	wire              buf_we    = (state_r == FBS_UNLOCK) | (go_write & (write_chk == FBS_ST_OK));
	wire [WW-1:0]     buf_waddr = idle ? word_addr : idx_r;
	wire [31:0]       buf_wdata = idle ? write_word : word_out;

	// Flash array and buffer carry no reset; erase a page before trusting it
	always_ff @(posedge ref_clk) begin
		if (clk_en && arr_we) begin
			copy0[arr_waddr] <= arr_wdata;
			copy1[arr_waddr] <= arr_wdata;
			copy2[arr_waddr] <= arr_wdata;
		end
		if (clk_en && buf_we) begin
			buf_mem[buf_waddr] <= buf_wdata;
		end
	end

	// ************************************************************
	// Per-page counters and flags
	// ************************************************************
	wire              prot_wr  = reg_write & (reg_addr == FBS_REG_PROT);
	wire [PW-1:0]     prot_pg  = reg_wdata[FBS_PROT_PG_LSB +: PW];

	for (genvar p = 0; p < PAGES; p++) begin : g_page
		wire hit_end = seq_end & (op_page_r == PW'(p));
		assign over[p] = (wcount_r[p] > WEAR_LIMIT);
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				wcount_r[p] <= FBS_CNT_RST;
				lock_r[p]   <= 1'b0;
				rprot_r[p]  <= 1'b0;
				wprot_r[p]  <= 1'b0;
			end else if (clk_en) begin
				if (hit_end && state_r != FBS_UNLOCK) begin
					wcount_r[p] <= wcount_r[p] + 24'h000001;
				end
				if (hit_end) begin
					lock_r[p] <= (state_r == FBS_PROGRAM) ? ow_req_r
						: (state_r == FBS_UNLOCK) ? 1'b0 : lock_r[p];
				end
				if (prot_wr && prot_pg == PW'(p)) begin
					rprot_r[p] <= reg_wdata[FBS_RPROT_BIT];
					wprot_r[p] <= reg_wdata[FBS_WPROT_BIT];
				end
			end
		end
	end

	// ************************************************************
	// Sequencer registers and page buffer bookkeeping
	// ************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r     <= FBS_IDLE;
			op_page_r   <= '0;
			idx_r       <= '0;
			err_acc_r   <= 2'h0;
			ow_req_r    <= 1'b0;
		end else if (clk_en) begin
			state_r   <= state_nxt;
			idx_r     <= idle ? '0 : idx_r + WW'(1);
			err_acc_r <= idle ? 2'h0 : unl_err;
			if (idle) begin
				op_page_r <= page_addr;
				ow_req_r  <= overwrite_lock_request;
			end
		end
	end

	// Buffer ownership: an unlock fills it whole, a write marks words modified
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			buf_page_r  <= '0;
			buf_dirty_r <= 1'b0;
			buf_mask_r  <= '0;
		end else if (clk_en) begin
			if (state_r == FBS_UNLOCK && last_idx) begin
				buf_page_r  <= op_page_r;
				buf_dirty_r <= 1'b0;
				buf_mask_r  <= '1;
			end else if (seq_end || (go_erase && erase_chk == FBS_ST_OK && same_buf)) begin
				buf_dirty_r <= 1'b0;
				buf_mask_r  <= '0;
			end else if (go_write && write_chk == FBS_ST_OK) begin
				buf_page_r  <= page_addr;
				buf_dirty_r <= 1'b1;
				buf_mask_r  <= (same_buf ? buf_mask_r : '0) | (WORDS'(1) << word_addr);
			end
		end
	end

	// ************************************************************
	// Fault hook synchroniser; it arrives from outside this clock
	// ************************************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fault_q1_r <= 32'h00000000;
			fault_q2_r <= 32'h00000000;
		end else if (clk_en) begin
			fault_q1_r <= fault_mask;
			fault_q2_r <= fault_q1_r;
		end
	end

	// ************************************************************
	// User-side outputs
	// ************************************************************
	// Status only moves on completion, so it may be sampled any time later
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status_r    <= FBS_ST_OK;
			op_done_r   <= 1'b0;
			read_word_r <= 32'h00000000;
			busy_r      <= 1'b0;
		end else if (clk_en) begin
			op_done_r <= fin;
			busy_r    <= (state_nxt != FBS_IDLE);
			if (fin) begin
				status_r <= fin_stat;
			end
			if (go_read) begin
				read_word_r <= read_nxt;
			end
		end
	end

	// ************************************************************
	// Register port and interrupt
	// ************************************************************
	wire [1:0] irq_set = {fin & (fin_stat != FBS_ST_OK), fin};
	wire [1:0] irq_clr = (reg_write && reg_addr == FBS_REG_IRQ_STAT) ? reg_wdata[1:0] : 2'h0;
	// Set wins over clear so an event in the clearing cycle survives
	wire [1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
	wire [31:0] rd_mux =
		(reg_addr == FBS_REG_IRQ_STAT) ? {30'h0, irq_stat_r}
		: (reg_addr == FBS_REG_IRQ_MASK) ? {30'h0, irq_mask_r}
		: (reg_addr == FBS_REG_LAST) ? {29'h0, busy_r, status_r}
		: 32'h00000000;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_r  <= FBS_IRQ_STAT_RST;
			irq_mask_r  <= FBS_IRQ_MASK_RST;
			reg_rdata_r <= 32'h00000000;
			irq_r       <= 1'b0;
		end else if (clk_en) begin
			irq_stat_r <= irq_stat_nxt;
			irq_r      <= |(irq_stat_nxt & irq_mask_r);
			if (reg_write && reg_addr == FBS_REG_IRQ_MASK) begin
				irq_mask_r <= reg_wdata[1:0];
			end
			reg_rdata_r <= reg_read ? rd_mux : 32'h00000000;
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign read_word = read_word_r;
	assign status    = status_r;
	assign op_done   = op_done_r;
	assign busy      = busy_r;
	assign irq       = irq_r;

endmodule : fbs_flash_block
`default_nettype wire

/* bench/fbs_flash_block_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Port checks for the flash block
// ************************************************************
module fbs_flash_block_props
	import fbs_pkg::*;
#(
	parameter int WORDS = 32
) (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        clk_en,
	input wire logic        write_strobe,
	input wire logic        read_strobe,
	input wire logic        page_info_select,
	input wire logic        page_unlock_request,
	input wire logic        program_request,
	input wire logic        erase_request,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] read_word,
	input wire logic [1:0]  status,
	input wire logic        op_done,
	input wire logic        busy,
	input wire logic        irq
);
	localparam int LD = WORDS + 1;
	// Requests taken this edge; a higher request hides the lower ones
	wire idle_go  = clk_en && !busy && !page_unlock_request && !program_request && !erase_request;
	wire wr_go    = idle_go && write_strobe;
	wire rd_go    = idle_go && !write_strobe && read_strobe;
	wire unl_go   = clk_en && !busy && page_unlock_request;
	wire mask_off = reg_write && reg_addr == FBS_REG_IRQ_MASK && reg_wdata[1:0] == 2'h0;
	wire rd_dead  = reg_read && (reg_addr[1:0] != 2'h0 || reg_addr == FBS_REG_PROT);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_status_held: assert property ($changed(status) |-> op_done)
		else $error("status moved without a completion");
	a_write_answer: assert property (wr_go |=> op_done && status != FBS_ST_UNCORR)
		else $error("write not completed next cycle");
	a_read_answer: assert property (rd_go |=> op_done)
		else $error("read not completed next cycle");
	a_info_word: assert property (rd_go && page_info_select |=> read_word[7:4] == 4'h0 && status == FBS_ST_OK)
		else $error("page info word malformed");
	a_unlock_time: assert property (unl_go |-> ##LD op_done && !busy)
		else $error("unlock length wrong");
	a_unlock_busy: assert property (unl_go |=> busy [*3] ##1 !op_done)
		else $error("busy dropped during unlock");
	a_busy_quiet: assert property (busy |-> !op_done)
		else $error("completion while busy");
	a_irq_masked: assert property (mask_off |=> ##1 !irq)
		else $error("irq high with all masked");
	a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("register data outside read");
	a_rdata_dead: assert property (rd_dead |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_last_view: assert property (reg_read && reg_addr == FBS_REG_LAST |=> reg_rdata == {29'h0, $past(busy), $past(status)})
		else $error("last operation register wrong");
endmodule : fbs_flash_block_props

bind fbs_flash_block fbs_flash_block_props #(.WORDS(WORDS)) props_u (
	.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .write_strobe(write_strobe), .read_strobe(read_strobe),
	.page_info_select(page_info_select), .page_unlock_request(page_unlock_request),
	.program_request(program_request), .erase_request(erase_request), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.read_word(read_word), .status(status), .op_done(op_done), .busy(busy), .irq(irq)
);
`default_nettype wire

/* bench/fbs_user_logic.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Fabric user logic driving the flash block
// ************************************************************
module fbs_user_logic (
	input  wire logic        ref_clk,
	input  wire logic        op_done,
	input  wire logic [1:0]  status,
	input  wire logic [31:0] read_word,
	output logic [4:0]       req,
	output logic [2:0]       page_addr,
	output logic [1:0]       word_addr,
	output logic [31:0]      write_word,
	output logic             info,
	output logic             lock
);
	// Idle levels at time zero
	initial begin
		req = 5'h00;
		page_addr = 3'h0;
		word_addr = 2'h0;
		write_word = 32'h0;
		info = 1'b0;
		lock = 1'b0;
	end

	// One request for one cycle, then a bounded wait for the completion pulse
	task automatic op(input logic [4:0] k, input logic [2:0] pg, input logic [1:0] wd, input logic [31:0] d,
		input logic [1:0] f, output logic [1:0] st, output logic [31:0] rw);
		st = 2'bxx;
		rw = 32'hx;
		@(posedge ref_clk);
		req        <= k;
		page_addr  <= pg;
		word_addr  <= wd;
		write_word <= d;
		{info, lock} <= f;
		@(posedge ref_clk);
		req        <= 5'h00;
		write_word <= ~d; // Released data must not look valid
		{info, lock} <= 2'h0;
		// Single-cycle answers stand right after the taking edge, so look before waiting
		for (int n = 0; n < 60; n++) begin
			#1;
			if (op_done === 1'b1) begin
				st = status;
				rw = read_word;
				break;
			end
			@(posedge ref_clk);
		end
	endtask : op
endmodule : fbs_user_logic
`default_nettype wire

/* bench/fbs_flash_block_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module fbs_flash_block_tb;
	import fbs_pkg::*;
	localparam logic [4:0]  UNL = 5'h10;
	localparam logic [4:0]  PRG = 5'h08;
	localparam logic [4:0]  ERS = 5'h04;
	localparam logic [4:0]  WRT = 5'h02;
	localparam logic [4:0]  RDW = 5'h01;
	localparam logic [1:0]  INF = 2'h2;
	localparam logic [31:0] DA  = 32'ha5c3_0f1e;
	localparam logic [31:0] DB  = 32'h1234_5678;
	logic        ref_clk;
	logic        nrst;
	logic [31:0] fault_mask;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_rdata;
	logic [31:0] read_word;
	logic [1:0]  status;
	logic        op_done;
	logic        busy;
	logic        irq;
	logic [4:0]  req;
	logic [2:0]  page_addr;
	logic [1:0]  word_addr;
	logic [31:0] write_word;
	logic        info;
	logic        lock;
	logic [1:0]  st;
	logic [31:0] rw;
	int          mismatches;
	int          n_checks;
	int          cyc;

	// Small word count and wear limit keep every sequence short
	fbs_flash_block #(.PAGES(8), .WORDS(4), .WEAR_LIMIT(24'h000002)) dut_u (
		.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1), .page_addr(page_addr), .word_addr(word_addr),
		.write_word(write_word), .write_strobe(req[1]), .read_strobe(req[0]), .page_info_select(info),
		.page_unlock_request(req[4]), .program_request(req[3]), .erase_request(req[2]),
		.overwrite_lock_request(lock), .fault_mask(fault_mask), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .read_word(read_word),
		.status(status), .op_done(op_done), .busy(busy), .irq(irq));
	fbs_user_logic usr_u (.ref_clk(ref_clk), .op_done(op_done), .status(status), .read_word(read_word),
		.req(req), .page_addr(page_addr), .word_addr(word_addr), .write_word(write_word), .info(info),
		.lock(lock));

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	// Hang guard, far above the 130 or so cycles the sequence needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic run(input logic [4:0] k, input logic [2:0] pg, input logic [1:0] wd, input logic [31:0] d,
		input logic [1:0] f, input logic [1:0] es);
		usr_u.op(k, pg, wd, d, f, st, rw);
		chk({30'h0, st}, {30'h0, es});
	endtask : run

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask : reg_wr

	task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : reg_chk

	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({31'h0, irq}, {31'h0, exp});
	endtask : irq_chk

	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{ref_clk, nrst, reg_write, reg_read, reg_addr} = 8'h00;
		{fault_mask, reg_wdata} = 64'h0;
		{mismatches, n_checks, cyc} = 96'h0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		chk({30'h0, status}, 32'h0);
		run(ERS, 3'h0, 2'h0, 32'h0, 2'h0, FBS_ST_OK);
		run(WRT, 3'h0, 2'h1, DA, 2'h0, FBS_ST_OK);
		run(PRG, 3'h0, 2'h0, 32'h0, 2'h1, FBS_ST_OK);
		run(RDW, 3'h0, 2'h1, 32'h0, 2'h0, FBS_ST_OK);
		chk(rw, DA);
		run(RDW, 3'h0, 2'h0, 32'h0, INF, FBS_ST_OK);
		chk(rw, 32'h0000_0201);
		run(WRT, 3'h0, 2'h2, DB, 2'h0, FBS_ST_FIX);
		run(UNL, 3'h0, 2'h0, 32'h0, 2'h0, FBS_ST_OK);
		run(RDW, 3'h0, 2'h0, 32'h0, INF, FBS_ST_OK);
		chk(rw, 32'h0000_0200);
		run(WRT, 3'h0, 2'h2, DB, 2'h0, FBS_ST_OK);
		run(WRT, 3'h1, 2'h0, DA, 2'h0, FBS_ST_WEAR);
		run(PRG, 3'h0, 2'h0, 32'h0, 2'h0, FBS_ST_OK);
		run(PRG, 3'h0, 2'h0, 32'h0, 2'h0, FBS_ST_FIX);
		run(RDW, 3'h0, 2'h1, 32'h0, 2'h0, FBS_ST_OK);
		chk(rw, DA);
		run(RDW, 3'h0, 2'h2, 32'h0, 2'h0, FBS_ST_OK);
		chk(rw, DB);
		run(RDW, 3'h0, 2'h0, 32'h0, INF, FBS_ST_OK);
		chk(rw, 32'h0000_0308);
		run(ERS, 3'h0, 2'h0, 32'h0, 2'h0, FBS_ST_WEAR);
		run(WRT, 3'h0, 2'h3, DB, 2'h0, FBS_ST_OK);
		run(PRG, 3'h0, 2'h0, 32'h0, 2'h0, FBS_ST_WEAR);
		reg_wr(FBS_REG_PROT, 32'h0000_0306);
		run(RDW, 3'h3, 2'h0, 32'h0, INF, FBS_ST_OK);
		chk(rw, 32'h0000_0006);
		// A program with the lock request set must refuse a later erase of that page
		run(ERS, 3'h4, 2'h0, 32'h0, 2'h0, FBS_ST_OK);
		run(UNL, 3'h4, 2'h0, 32'h0, 2'h0, FBS_ST_OK);
		run(WRT, 3'h4, 2'h0, DA, 2'h0, FBS_ST_OK);
		run(PRG, 3'h4, 2'h0, 32'h0, 2'h1, FBS_ST_OK);
		run(ERS, 3'h4, 2'h0, 32'h0, 2'h0, FBS_ST_FIX);
		// Faults reach the array through a two-flop synchroniser, so allow it to settle
		run(ERS, 3'h2, 2'h0, 32'h0, 2'h0, FBS_ST_OK);
		@(posedge ref_clk);
		fault_mask <= 32'h0000_0100;
		repeat (4) @(posedge ref_clk);
		run(RDW, 3'h2, 2'h1, 32'h0, 2'h0, FBS_ST_FIX);
		chk(rw, 32'h0);
		@(posedge ref_clk);
		fault_mask <= 32'h0000_0003;
		repeat (4) @(posedge ref_clk);
		run(RDW, 3'h2, 2'h1, 32'h0, 2'h0, FBS_ST_UNCORR);
		chk(rw, 32'h0000_0003);
		run(UNL, 3'h2, 2'h0, 32'h0, 2'h0, FBS_ST_UNCORR);
		// Interrupt status, mask and clear
		reg_chk(FBS_REG_IRQ_STAT, 32'h3);
		irq_chk(1'b0);
		reg_wr(FBS_REG_IRQ_MASK, 32'h2);
		irq_chk(1'b1);
		reg_chk(FBS_REG_IRQ_MASK, 32'h2);
		reg_wr(FBS_REG_IRQ_STAT, 32'h2);
		irq_chk(1'b0);
		reg_chk(FBS_REG_IRQ_STAT, 32'h1);
		reg_wr(FBS_REG_IRQ_MASK, 32'h0);
		reg_chk(4'h2, 32'h0);
		reg_chk(FBS_REG_PROT, 32'h0);
		reg_chk(FBS_REG_LAST, 32'h2);
		test_done();
	end
endmodule : fbs_flash_block_tb
`default_nettype wire
